// ---- design/pcmd_pkg.sv ----
// Package of constants for the primary command register block
package pcmd_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] CMD_OFFSET     = 12'h004;
  localparam int          CMD_WIDTH      = 16;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0547;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int IO_EN_BIT     = 0;
  localparam int MEM_EN_BIT    = 1;
  localparam int MASTER_EN_BIT = 2;
  localparam int PERR_RESP_BIT = 6;
  localparam int SERR_EN_BIT   = 8;
  localparam int INTX_DIS_BIT  = 10;
  // Status flag position within the status half (bit 24 of the dword)
  localparam int MDPE_BIT      = 8;
  // ---------------------------------------------------------------
  // Bridge direction
  // ---------------------------------------------------------------
  typedef enum logic {PCMD_FORWARD, PCMD_REVERSE} pcmd_dir_t;
endpackage : pcmd_pkg

// ---- design/pcmd_flag.sv ----
// Write-one-to-clear status flag with set priority
`timescale 1ns/1ns
`default_nettype none
module pcmd_flag (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic set_req,
  input  wire logic clr_req,
  output logic      flag
);
  logic flag_ff;
  logic nxt_flag;

  always_comb begin
    nxt_flag = flag_ff;
    if (set_req) begin
      nxt_flag = 1'b1;
    end else if (clr_req) begin
      nxt_flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;
endmodule // pcmd_flag
`default_nettype wire

// ---- design/pcmd_primary_command.sv ----
// Primary command register with its traffic gates
`timescale 1ns/1ns
`default_nettype none
module pcmd_primary_command (
  input  wire logic        clk,
  input  wire logic        nrst,
  // Configuration access from the primary side
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_hit,
  // Bridge mode
  input  wire logic        dir_reverse,
  input  wire logic        pcix_mode,
  // Primary target requests
  input  wire logic        p_io_req,
  input  wire logic        p_mem_rd_req,
  input  wire logic        p_mem_wr_req,
  input  wire logic        p_special_req,
  input  wire logic        p_palette_req,
  output logic             p_io_accept,
  output logic             p_mem_rd_accept,
  output logic             p_mem_wr_accept,
  output logic             p_special_accept,
  output logic             p_palette_snoop,
  // Primary mastering and secondary response
  input  wire logic        fwd_master_req,
  input  wire logic        mwi_forward,
  input  wire logic        split_cpl_req,
  input  wire logic        s_memio_req,
  output logic             p_master_grant,
  output logic             p_mwi_allow,
  output logic             split_cpl_grant,
  output logic             s_memio_accept,
  // Error reporting
  input  wire logic        parity_event,
  input  wire logic        sys_err_event,
  output logic             err_msg_send,
  output logic             serr_drive,
  output logic             mdpe_flag,
  // Legacy interrupt
  input  wire logic        intx_req,
  output logic             intx_assert
);
  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic is_cmd(input logic [11:0] a);
    is_cmd = (a == pcmd_pkg::CMD_OFFSET);
  endfunction

  logic wr_hit;
  logic rd_hit;
  assign wr_hit  = cfg_wr && is_cmd(cfg_addr);
  assign rd_hit  = cfg_rd && is_cmd(cfg_addr);
  assign cfg_hit = (cfg_wr || cfg_rd) && is_cmd(cfg_addr);

  // ---------------------------------------------------------------
  // Command register
  // ---------------------------------------------------------------
  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;
  logic [15:0] be_mask;

  always_comb begin
    be_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
    nxt_cmd = cmd_ff;
    if (wr_hit) begin
      // Only writable bits take data; fixed bits stay zero
      nxt_cmd = (cmd_ff & ~(be_mask & pcmd_pkg::CMD_WRITE_MASK))
              | (cfg_wdata[15:0] & be_mask
                 & pcmd_pkg::CMD_WRITE_MASK);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ff <= pcmd_pkg::CMD_RESET;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  logic io_en;
  logic mem_en;
  logic master_en;
  logic perr_resp;
  logic system_error_report_gate;
  logic intx_dis;
  assign io_en     = cmd_ff[pcmd_pkg::IO_EN_BIT];
  assign mem_en    = cmd_ff[pcmd_pkg::MEM_EN_BIT];
  assign master_en = cmd_ff[pcmd_pkg::MASTER_EN_BIT];
  assign perr_resp = cmd_ff[pcmd_pkg::PERR_RESP_BIT];
  assign system_error_report_gate = cmd_ff[pcmd_pkg::SERR_EN_BIT];
  assign intx_dis  = cmd_ff[pcmd_pkg::INTX_DIS_BIT];

  // ---------------------------------------------------------------
  // Master data parity status flag
  // ---------------------------------------------------------------
  logic mdpe_set;
  logic mdpe_clr;
  assign mdpe_set = parity_event && perr_resp;
  assign mdpe_clr = wr_hit && cfg_be[3]
                 && cfg_wdata[16 + pcmd_pkg::MDPE_BIT];

  pcmd_flag u_mdpe (
    .clk     (clk),
    .nrst    (nrst),
    .set_req (mdpe_set),
    .clr_req (mdpe_clr),
    .flag    (mdpe_flag)
  );

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_hit) begin
      nxt_rdata = 32'h0000_0000;
      // Fixed bits 3,4,5,7,9 and 15:11 read zero
      nxt_rdata[15:0] = cmd_ff & pcmd_pkg::CMD_WRITE_MASK;
      nxt_rdata[16 + pcmd_pkg::MDPE_BIT] = mdpe_flag;
    end else if (cfg_rd) begin
      nxt_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata = rdata_ff;

  // ---------------------------------------------------------------
  // Primary target gates
  // ---------------------------------------------------------------
  assign p_io_accept      = p_io_req && io_en;
  assign p_mem_rd_accept  = p_mem_rd_req && mem_en;
  assign p_mem_wr_accept  = p_mem_wr_req && mem_en;
  assign p_special_accept = 1'b0 & p_special_req;
  assign p_palette_snoop  = 1'b0 & p_palette_req;

  // ---------------------------------------------------------------
  // Mastering gates
  // ---------------------------------------------------------------
  assign p_master_grant  = fwd_master_req && master_en;
  assign s_memio_accept  = s_memio_req && master_en;
  // Write-and-invalidate only passes through when forwarded with mastering enabled and not in PCI-X mode
  assign p_mwi_allow     = mwi_forward && master_en && !pcix_mode;
  assign split_cpl_grant = split_cpl_req
                        && (master_en || (dir_reverse && pcix_mode));

  // ---------------------------------------------------------------
  // Error reporting and interrupt
  // ---------------------------------------------------------------
  logic serr_ff;
  logic nxt_serr;
  logic intx_ff;
  logic nxt_intx;

  always_comb begin
    nxt_serr = sys_err_event && system_error_report_gate
            && dir_reverse;
    nxt_intx = intx_req && !intx_dis;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serr_ff <= 1'b0;
      intx_ff <= 1'b0;
    end else begin
      serr_ff <= nxt_serr;
      intx_ff <= nxt_intx;
    end
  end

  assign err_msg_send = sys_err_event && system_error_report_gate
                     && !dir_reverse;
  assign serr_drive   = serr_ff;
  assign intx_assert  = intx_ff;
endmodule // pcmd_primary_command
`default_nettype wire

// ---- bench/pcmd_checker.sv ----
// Port checker for the primary command register block
`timescale 1ns/1ns
`default_nettype none
module pcmd_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic        cfg_hit,
  input wire logic [31:0] cfg_rdata,
  input wire logic        dir_reverse,
  input wire logic        pcix_mode,
  input wire logic        p_io_req,
  input wire logic        p_io_accept,
  input wire logic        p_special_accept,
  input wire logic        p_palette_snoop,
  input wire logic        split_cpl_req,
  input wire logic        split_cpl_grant,
  input wire logic        sys_err_event,
  input wire logic        err_msg_send,
  input wire logic        parity_event,
  input wire logic        mdpe_flag,
  input wire logic        intx_req,
  input wire logic        intx_assert
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_io; p_io_accept |-> p_io_req; endproperty
  a_io: assert property (p_io) else $error("io accept");
  property p_spl; split_cpl_req && dir_reverse && pcix_mode
    |-> split_cpl_grant; endproperty
  a_spl: assert property (p_spl) else $error("split grant");
  property p_none; !(p_special_accept || p_palette_snoop); endproperty
  a_none: assert property (p_none) else $error("special");
  property p_ro; cfg_rd && cfg_hit |=> (cfg_rdata & 32'hFEFFFAB8) == 0;
  endproperty
  a_ro: assert property (p_ro) else $error("ro bits");
  property p_um; cfg_rd && !cfg_hit |=> cfg_rdata == 32'h00000000;
  endproperty
  a_um: assert property (p_um) else $error("unmapped");
  property p_err; err_msg_send |-> sys_err_event && !dir_reverse;
  endproperty
  a_err: assert property (p_err) else $error("err msg");
  property p_intx; intx_assert |-> $past(intx_req); endproperty
  a_intx: assert property (p_intx) else $error("intx");
  property p_set; $rose(mdpe_flag) |-> $past(parity_event); endproperty
  a_set: assert property (p_set) else $error("flag set");
  property p_clr; $fell(mdpe_flag) |-> $past(cfg_wr); endproperty
  a_clr: assert property (p_clr) else $error("flag clear");
  cover property (cfg_wr && cfg_hit);
  cover property (mdpe_flag);
  cover property (intx_assert);
endmodule // pcmd_checker
bind pcmd_primary_command pcmd_checker pcmd_checker_i (.*);
`default_nettype wire

// ---- bench/pcmd_host.sv ----
// Host configuration software model on the primary bus
`timescale 1ns/1ns
`default_nettype none
module pcmd_host (
  input  wire logic        clk,
  input  wire logic [31:0] cfg_rdata,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [11:0]      cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata
);
  initial begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  // One-cycle strobe, data inverted once released
  task automatic acc(input logic w, input logic [11:0] a,
    input logic [3:0] b, input logic [31:0] d, output logic [31:0] q);
    @(negedge clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, b, d};
    @(negedge clk);
    {cfg_wr, cfg_rd, cfg_wdata} = {2'b00, ~d};
    q = cfg_rdata;
  endtask
endmodule // pcmd_host
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench of the primary command register
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, nrst, cfg_wr, cfg_rd, cfg_hit, dir_reverse, pcix_mode;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, q;
  logic p_io_req, p_mem_rd_req, p_mem_wr_req, p_special_req, p_palette_req;
  logic p_io_accept, p_mem_rd_accept, p_mem_wr_accept, p_special_accept;
  logic p_palette_snoop, fwd_master_req, mwi_forward, split_cpl_req;
  logic s_memio_req, p_master_grant, p_mwi_allow, split_cpl_grant;
  logic s_memio_accept, parity_event, sys_err_event, err_msg_send;
  logic serr_drive, mdpe_flag, intx_req, intx_assert;
  int failures, tests_run;
  pcmd_primary_command pcmd_primary_command_i (.*);
  pcmd_host pcmd_host_i (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [3:0] b, logic [31:0] d);
    pcmd_host_i.acc(1'b1, a, b, d, q);
  endtask
  task automatic rd(logic [11:0] a);
    pcmd_host_i.acc(1'b0, a, 4'hF, 32'h0, q);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_regs();
    rd(12'h004);
    chk("reset", q, 32'h0);
    wr(12'h004, 4'hF, 32'hFFFFFFFF);
    rd(12'h004);
    chk("mask", q, 32'h547);
    wr(12'h008, 4'hF, 32'h0);
    rd(12'h008);
    chk("unmapped", q, 32'h0);
    wr(12'h004, 4'h2, 32'h0);
    rd(12'h004);
    chk("lane", q, 32'h47);
    $display("test regs done");
  endtask
  task automatic t_gates();
    logic [8:0] e;
    for (int i = 0; i < 32; i++) begin
      {dir_reverse, pcix_mode} = 2'(i >> 3);
      wr(12'h004, 4'h1, 32'(i & 7));
      e = {i[0], i[1], i[1], 2'b00, i[2], i[2] & !i[3],
           i[2] | (i[4] & i[3]), i[2]};
      chk("gates", {p_io_accept, p_mem_rd_accept, p_mem_wr_accept,
        p_special_accept, p_palette_snoop, p_master_grant, p_mwi_allow,
        split_cpl_grant, s_memio_accept}, 32'(e));
    end
    $display("test gates done");
  endtask
  task automatic t_err();
    for (int i = 0; i < 2; i++) begin
      wr(12'h004, 4'h1, i ? 32'h40 : 32'h0);
      parity_event = 1'b1;
      @(negedge clk);
      parity_event = 1'b0;
      chk("flag", 32'(mdpe_flag), 32'(i));
    end
    rd(12'h004);
    chk("flag read", 32'(q[24]), 32'h1);
    wr(12'h004, 4'h8, 32'h01000000);
    chk("w1c", 32'(mdpe_flag), 32'h0);
    {dir_reverse, sys_err_event} = 2'b01;
    wr(12'h004, 4'h2, 32'h100);
    chk("msg", 32'(err_msg_send), 32'h1);
    dir_reverse = 1'b1;
    @(negedge clk);
    chk("serr", {err_msg_send, serr_drive}, 32'h1);
    $display("test err done");
  endtask
  task automatic t_intx();
    intx_req = 1'b1;
    wr(12'h004, 4'h2, 32'h0);
    chk("intx on", 32'(intx_assert), 32'h1);
    wr(12'h004, 4'h2, 32'h400);
    @(negedge clk);
    chk("intx off", 32'(intx_assert), 32'h0);
    $display("test intx done");
  endtask
  initial begin
    {nrst, dir_reverse, pcix_mode, parity_event, sys_err_event} = '0;
    {p_io_req, p_mem_rd_req, p_mem_wr_req, p_special_req} = '1;
    {p_palette_req, fwd_master_req, mwi_forward, split_cpl_req} = '1;
    {s_memio_req, intx_req, failures, tests_run} = '0;
    s_memio_req = 1'b1;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_gates();
    t_err();
    t_intx();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
